// file: common/dio_deb_if.sv
// Link between the top level and one debounce filter channel
`timescale 1ns/10ps
interface dio_deb_if;
    import dio_pkg::*;

    logic            raw;
    logic            tick;
    logic [CNTW-1:0] target;
    logic            level;

    modport ctl (output raw, output tick, output target, input level);
    modport flt (input raw, input tick, input target, output level);
endinterface

// file: common/dio_pkg.sv
// Constants, register map and timing figures of the debounced digital I/O block
//
// Summary of operation
// - Forty-eight buffered inputs, each with its own debounce filter; all share one programmable length.
// - Each filter is a counter; a new level is accepted once the count is reached.
// - Duration code 00/01/10/11 selects 32/512/8000/64000 debounce clock periods.
// - Debounce clock is the internal 8MHz rate or an external clock on pin 47.
// - Debounce time may deviate by up to two debounce clock periods.
// - Every channel can flag a falling edge, rising edge or change of state, except channel 47 while it carries the external debounce clock.
// - Change-of-state detection works on a pair of input channels.
// - Register space supports 16-bit accesses and 8-bit accesses of the low byte.
// - Identification space reads 32 type 1 bytes at consecutive odd addresses.
// - For 200ms after power-up all bus signals are ignored; host expects nothing.
// - Every read and write completes with zero wait states.
// - The 48 points are open-drain: pulled low when output bit set, else released.
package dio_pkg;

    localparam int NCH       = 48;
    localparam int DW        = 16;
    localparam int AW        = 6;
    localparam int CNTW      = 16;
    localparam int NPAIR     = NCH / 2;
    localparam int EXT_CH    = 47;

    // Clock rates and the power-up blackout
    localparam int CLK_MHZ        = 50;
    localparam int DEB_MHZ        = 8;
    localparam int BLACKOUT_MS    = 200;
    localparam int BLACKOUT_CYC   = BLACKOUT_MS * CLK_MHZ * 1000;
    localparam int BLKW           = 24;
    localparam logic [6:0] ACC_STEP = 7'(DEB_MHZ);
    localparam logic [6:0] ACC_WRAP = 7'(CLK_MHZ);

    // Debounce counts per duration code
    localparam logic [CNTW-1:0] DEB_CNT_0 = 16'd32;
    localparam logic [CNTW-1:0] DEB_CNT_1 = 16'd512;
    localparam logic [CNTW-1:0] DEB_CNT_2 = 16'd8000;
    localparam logic [CNTW-1:0] DEB_CNT_3 = 16'd64000;

    // Register byte addresses; data, enable, type and pending are groups of three 16-bit words
    localparam logic [AW-1:0] ADDR_DATA = 6'h00;
    localparam logic [AW-1:0] ADDR_EN   = 6'h06;
    localparam logic [AW-1:0] ADDR_TYPE = 6'h0c;
    localparam logic [AW-1:0] ADDR_PEND = 6'h12;
    localparam logic [AW-1:0] ADDR_COS0 = 6'h18;
    localparam logic [AW-1:0] ADDR_COS1 = 6'h1a;
    localparam logic [AW-1:0] ADDR_CTRL = 6'h1c;
    localparam logic [AW-1:0] WORD_STEP = 6'h02;
    localparam int            NWORD     = 3;

    // Control word fields
    localparam int CTRL_DUR_LSB = 0;
    localparam int CTRL_EXT_BIT = 2;
    localparam int CTRL_W       = 3;

    localparam logic [DW-1:0] LOW_BYTE = 16'h00ff;
    localparam logic [DW-1:0] ALL_BITS = 16'hffff;
    localparam logic          PIN_IDLE = 1'b1;

    // Identification space
    localparam int ID_BYTES = 32;
    localparam logic [7:0] ID_CHR_I = 8'h49;
    localparam logic [7:0] ID_CHR_P = 8'h50;
    localparam logic [7:0] ID_CHR_A = 8'h41;
    localparam logic [7:0] ID_CHR_C = 8'h43;
    localparam logic [7:0] ID_USED  = 8'h0c;

endpackage

// file: src/dio_debounce.sv
// One counter-based debounce filter channel
`timescale 1ns/10ps
module dio_debounce
    import dio_pkg::*;
(
    input  wire logic I_MCLK,
    input  wire logic I_RST_N,
    dio_deb_if.flt    deb
);

    logic [CNTW-1:0] cnt_q;
    logic            level_q;

    assign deb.level = level_q;

    ////////////////////////////////////////////////////////////////////////
    // Count debounce clock periods while raw differs from accepted level
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_q   <= '0;
            level_q <= PIN_IDLE;
        end else if (deb.raw == level_q) begin
            cnt_q <= '0;
        end else if (deb.tick) begin
            if (cnt_q + 16'h0001 >= deb.target) begin
                level_q <= deb.raw;
                cnt_q   <= '0;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

endmodule

// file: src/dio_top.sv
// Debounced 48-channel open-drain digital I/O port with event flags
`timescale 1ns/10ps
module dio_top
    import dio_pkg::*;
#(
    parameter int         BLACKOUT_CYCLES = BLACKOUT_CYC,
    // Identification values; arbitrary neutral defaults
    parameter logic [7:0] ID_MAKER        = 8'h5a,
    parameter logic [7:0] ID_MODEL        = 8'h21,
    parameter logic [7:0] ID_REV          = 8'h01
)
(
    input  wire logic          I_MCLK,
    input  wire logic          I_RST_N,
    input  wire logic [AW-1:0] I_ADDR,
    input  wire logic [DW-1:0] I_WDATA,
    input  wire logic          I_WR,
    input  wire logic          I_RD,
    input  wire logic          I_BYTE,
    input  wire logic          I_ID_SEL,
    output logic      [DW-1:0] O_RDATA,
    input  wire logic [NCH-1:0] I_IO_I,
    output logic      [NCH-1:0] O_IO_O,
    output logic      [NCH-1:0] O_IO_OE,
    output logic               O_EVENT,
    output logic               O_READY
);

    ////////////////////////////////////////////////////////////////////////
    // Power-up blackout

    logic [BLKW-1:0] blk_cnt_q;
    logic            ready_q;

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            blk_cnt_q <= '0;
            ready_q   <= 1'b0;
        end else if (!ready_q) begin
            if (blk_cnt_q >= BLKW'(BLACKOUT_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end else begin
                blk_cnt_q <= blk_cnt_q + 24'h000001;
            end
        end
    end

    assign O_READY = ready_q;

    logic wr_ok;
    logic rd_ok;

    assign wr_ok = I_WR && ready_q && !I_ID_SEL;
    assign rd_ok = I_RD && ready_q;

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [NCH-1:0]    out_q;
    logic [NCH-1:0]    en_q;
    logic [NCH-1:0]    type_q;
    logic [NCH-1:0]    pend_q;
    logic [NPAIR-1:0]  cos_q;
    logic [CTRL_W-1:0] ctrl_q;

    logic [DW-1:0]     lane_mask;
    logic [NCH-1:0]    wmask_data;
    logic [NCH-1:0]    wmask_en;
    logic [NCH-1:0]    wmask_type;
    logic [NCH-1:0]    wmask_pend;
    logic [NCH-1:0]    wdata_rep;
    logic [2*DW-1:0]   wmask_cos;
    logic [NPAIR-1:0]  cos_wr;
    logic              wr_ctrl;
    assign lane_mask = I_BYTE ? LOW_BYTE : ALL_BITS;
    assign wdata_rep = {I_WDATA, I_WDATA, I_WDATA};
    assign cos_wr    = NPAIR'({I_WDATA, I_WDATA} & wmask_cos);

    // Per-word write masks for the three-word groups
    always_comb begin
        wmask_data = '0;
        wmask_en   = '0;
        wmask_type = '0;
        wmask_pend = '0;
        wmask_cos  = '0;
        for (int n = 0; n < NWORD; n++) begin
            if (wr_ok && I_ADDR == ADDR_DATA + AW'(n) * WORD_STEP) begin
                wmask_data[n*DW +: DW] = lane_mask;
            end
            if (wr_ok && I_ADDR == ADDR_EN + AW'(n) * WORD_STEP) begin
                wmask_en[n*DW +: DW] = lane_mask;
            end
            if (wr_ok && I_ADDR == ADDR_TYPE + AW'(n) * WORD_STEP) begin
                wmask_type[n*DW +: DW] = lane_mask;
            end
            if (wr_ok && I_ADDR == ADDR_PEND + AW'(n) * WORD_STEP) begin
                wmask_pend[n*DW +: DW] = lane_mask;
            end
        end
        if (wr_ok && I_ADDR == ADDR_COS0) begin
            wmask_cos[DW-1:0] = lane_mask;
        end
        if (wr_ok && I_ADDR == ADDR_COS1) begin
            wmask_cos[2*DW-1:DW] = lane_mask;
        end
    end

    assign wr_ctrl = wr_ok && I_ADDR == ADDR_CTRL;

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            out_q <= '0;
        end else begin
            out_q <= (out_q & ~wmask_data) | (wdata_rep & wmask_data);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            en_q   <= '0;
            type_q <= '0;
        end else begin
            en_q   <= (en_q & ~wmask_en) | (wdata_rep & wmask_en);
            type_q <= (type_q & ~wmask_type) | (wdata_rep & wmask_type);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cos_q <= '0;
        end else begin
            cos_q <= (cos_q & ~wmask_cos[NPAIR-1:0]) | cos_wr;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q <= I_WDATA[CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain output drive

    assign O_IO_O  = '0;
    assign O_IO_OE = out_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    logic [NCH-1:0] sync1_q;
    logic [NCH-1:0] sync2_q;
    logic [NCH-1:0] sync3_q;
    logic [NCH-1:0] pin_q;
    logic [NCH-1:0] agree;

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sync1_q <= {NCH{PIN_IDLE}};
            sync2_q <= {NCH{PIN_IDLE}};
            sync3_q <= {NCH{PIN_IDLE}};
        end else begin
            sync1_q <= I_IO_I;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign agree = ~(sync2_q ^ sync3_q);

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_q <= {NCH{PIN_IDLE}};
        end else begin
            pin_q <= (sync2_q & agree) | (pin_q & ~agree);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce clock: 8MHz rate from fractional accumulator or external pin

    logic [6:0] acc_q;
    logic       int_tick_q;
    logic       ext_prev_q;
    logic       ext_tick;
    logic       ext_sel;
    logic       deb_tick;

    assign ext_sel = ctrl_q[CTRL_EXT_BIT];

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            acc_q      <= '0;
            int_tick_q <= 1'b0;
        end else if (acc_q + ACC_STEP >= ACC_WRAP) begin
            acc_q      <= acc_q + ACC_STEP - ACC_WRAP;
            int_tick_q <= 1'b1;
        end else begin
            acc_q      <= acc_q + ACC_STEP;
            int_tick_q <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ext_prev_q <= PIN_IDLE;
        end else begin
            ext_prev_q <= pin_q[EXT_CH];
        end
    end

    // Rising edge of the filtered external clock pin
    assign ext_tick = pin_q[EXT_CH] && !ext_prev_q;
    assign deb_tick = ext_sel ? ext_tick : int_tick_q;

    logic [CNTW-1:0] deb_target;

    always_comb begin
        case (ctrl_q[CTRL_DUR_LSB +: 2])
            2'h0:    deb_target = DEB_CNT_0;
            2'h1:    deb_target = DEB_CNT_1;
            2'h2:    deb_target = DEB_CNT_2;
            2'h3:    deb_target = DEB_CNT_3;
            default: deb_target = DEB_CNT_0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce filters, one per channel

    logic [NCH-1:0] deb_lvl;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_deb
        dio_deb_if link ();

        assign link.raw    = pin_q[ch];
        assign link.tick   = deb_tick;
        assign link.target = deb_target;
        assign deb_lvl[ch] = link.level;

        dio_debounce u_deb (
            .I_MCLK  (I_MCLK),
            .I_RST_N (I_RST_N),
            .deb     (link.flt)
        );
    end

    // Channel 47 carries the debounce clock when external is chosen
    logic [NCH-1:0] in_mask;
    logic [NCH-1:0] in_val;

    always_comb begin
        in_mask         = '1;
        in_mask[EXT_CH] = !ext_sel;
    end

    assign in_val = deb_lvl & in_mask;

    ////////////////////////////////////////////////////////////////////////
    // Event detection on debounced levels

    logic [NCH-1:0] deb_prev_q;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] event_hit;
    logic [NCH-1:0] pair_cos;

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            deb_prev_q <= {NCH{PIN_IDLE}};
        end else begin
            deb_prev_q <= deb_lvl;
        end
    end

    assign rise = deb_lvl & ~deb_prev_q;
    assign fall = ~deb_lvl & deb_prev_q;

    always_comb begin
        for (int p = 0; p < NPAIR; p++) begin
            pair_cos[2*p]   = cos_q[p];
            pair_cos[2*p+1] = cos_q[p];
        end
    end

    // Type bit set: rising edge; clear: falling edge; pair COS: either edge
    assign event_hit = en_q & in_mask
                     & ((pair_cos & (rise | fall))
                     | (~pair_cos & type_q & rise)
                     | (~pair_cos & ~type_q & fall));

    // A new event wins over a clear in the same cycle
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~(wdata_rep & wmask_pend)) | event_hit;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_EVENT <= 1'b0;
        end else begin
            O_EVENT <= |pend_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identification space, odd byte addresses only

    logic [7:0] id_byte;

    always_comb begin
        id_byte = '0;
        if (I_ADDR[0]) begin
            case (I_ADDR[AW-1:1])
                5'h00:   id_byte = ID_CHR_I;
                5'h01:   id_byte = ID_CHR_P;
                5'h02:   id_byte = ID_CHR_A;
                5'h03:   id_byte = ID_CHR_C;
                5'h04:   id_byte = ID_MAKER;
                5'h05:   id_byte = ID_MODEL;
                5'h06:   id_byte = ID_REV;
                5'h0b:   id_byte = ID_USED;
                default: id_byte = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: data in the cycle after the strobe

    logic [DW-1:0] rd_word;

    always_comb begin
        rd_word = '0;
        for (int n = 0; n < NWORD; n++) begin
            if (I_ADDR == ADDR_DATA + AW'(n) * WORD_STEP) begin
                rd_word = in_val[n*DW +: DW];
            end
            if (I_ADDR == ADDR_EN + AW'(n) * WORD_STEP) begin
                rd_word = en_q[n*DW +: DW];
            end
            if (I_ADDR == ADDR_TYPE + AW'(n) * WORD_STEP) begin
                rd_word = type_q[n*DW +: DW];
            end
            if (I_ADDR == ADDR_PEND + AW'(n) * WORD_STEP) begin
                rd_word = pend_q[n*DW +: DW];
            end
        end
        if (I_ADDR == ADDR_COS0) begin
            rd_word = cos_q[DW-1:0];
        end
        if (I_ADDR == ADDR_COS1) begin
            rd_word = DW'(cos_q[NPAIR-1:DW]);
        end
        if (I_ADDR == ADDR_CTRL) begin
            rd_word = DW'(ctrl_q);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= '0;
        end else if (rd_ok && I_ID_SEL) begin
            O_RDATA <= DW'(id_byte);
        end else if (rd_ok) begin
            O_RDATA <= rd_word & lane_mask;
        end else begin
            O_RDATA <= '0;
        end
    end

endmodule

// file: test/dio_field.sv
// Field side of the I/O points: pull-ups and switches to ground
`timescale 1ns/10ps
module dio_field
    import dio_pkg::*;
(
    input  wire logic [NCH-1:0] i_oe,
    input  wire logic [NCH-1:0] i_sw,
    output logic      [NCH-1:0] o_pin
);
    // Pull-up wins unless a party sinks the point
    assign o_pin = ~(i_oe | i_sw);
endmodule

// file: test/dio_properties.sv
// Port-level properties of the debounced I/O block
`timescale 1ns/10ps
module dio_properties
    import dio_pkg::*;
#(
    parameter int BLACKOUT_CYCLES = BLACKOUT_CYC
)
(
    input wire logic           I_MCLK,
    input wire logic           I_RST_N,
    input wire logic [AW-1:0]  I_ADDR,
    input wire logic [DW-1:0]  I_WDATA,
    input wire logic           I_WR,
    input wire logic           I_RD,
    input wire logic           I_BYTE,
    input wire logic           I_ID_SEL,
    input wire logic [DW-1:0]  O_RDATA,
    input wire logic [NCH-1:0] I_IO_I,
    input wire logic [NCH-1:0] O_IO_O,
    input wire logic [NCH-1:0] O_IO_OE,
    input wire logic           O_EVENT,
    input wire logic           O_READY
);
    logic [31:0] wait_q;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wait_q <= '0;
        end else if (!O_READY) begin
            wait_q <= wait_q + 32'h1;
        end
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    ////////////////////////////////////////////////////////////////////////
    sink_only_a: assert property (O_IO_O == '0)
        else $error("pin driven high");
    blackout_len_a: assert property ($rose(O_READY) |->
        (wait_q + 32'h1 >= 32'(BLACKOUT_CYCLES) && wait_q <= 32'(BLACKOUT_CYCLES + 2)))
        else $error("blackout length wrong");
    ready_holds_a: assert property (O_READY |=> O_READY)
        else $error("ready dropped");
    quiet_blackout_a: assert property (!O_READY |-> !O_EVENT && O_IO_OE == '0)
        else $error("activity during blackout");
    rdata_idle_a: assert property (!($past(I_RD) && $past(O_READY)) |-> O_RDATA == '0)
        else $error("read data outside its cycle");
    narrow_read_a: assert property (I_RD && O_READY && (I_BYTE || I_ID_SEL)
        |=> O_RDATA[15:8] == 8'h00) else $error("high byte on narrow read");
    id_even_a: assert property (I_RD && O_READY && I_ID_SEL && !I_ADDR[0]
        |=> O_RDATA == '0) else $error("even id address data");
    id_first_a: assert property (I_RD && O_READY && I_ID_SEL && I_ADDR == 6'h01
        |=> O_RDATA[7:0] == ID_CHR_I) else $error("id byte zero wrong");
    out_write_a: assert property (I_WR && O_READY && !I_ID_SEL && I_ADDR == ADDR_DATA
        |=> O_IO_OE[15:0] == ($past(I_BYTE) ? {$past(O_IO_OE[15:8]), $past(I_WDATA[7:0])}
        : $past(I_WDATA))) else $error("output word not written");
    out_hold_a: assert property (!I_WR |=> $stable(O_IO_OE))
        else $error("outputs changed without write");
endmodule
bind dio_top dio_properties #(.BLACKOUT_CYCLES(BLACKOUT_CYCLES)) u_props (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .I_BYTE(I_BYTE), .I_ID_SEL(I_ID_SEL), .O_RDATA(O_RDATA), .I_IO_I(I_IO_I),
    .O_IO_O(O_IO_O), .O_IO_OE(O_IO_OE), .O_EVENT(O_EVENT), .O_READY(O_READY));

// file: test/tb_debounced_io_pack_inputs.sv
// Register-level testbench of the debounced I/O block
`timescale 1ns/10ps
module tb_debounced_io_pack_inputs;
    import dio_pkg::*;
    // Identification values are arbitrary
    localparam logic [7:0] MK = 8'h3c;
    localparam logic [7:0] MD = 8'h77;
    localparam logic [7:0] RV = 8'h02;
    logic mclk = 0, rst_n = 0, wrs = 0, rds = 0, byt = 0, ids = 0, evt, rdy;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdat = '0, rdat;
    logic [NCH-1:0] sw = '0, pin, oo, oe;
    logic [7:0] idt [0:11] = '{ID_CHR_I, ID_CHR_P, ID_CHR_A, ID_CHR_C, MK, MD, RV,
                               8'h00, 8'h00, 8'h00, 8'h00, ID_USED};
    logic [CNTW-1:0] cnt [0:2] = '{DEB_CNT_0, DEB_CNT_1, DEB_CNT_2};
    int error_cnt = 0, compares = 0, n;
    always #10 mclk = ~mclk;
    dio_top #(.BLACKOUT_CYCLES(20), .ID_MAKER(MK), .ID_MODEL(MD), .ID_REV(RV)) uut (
        .I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wrs),
        .I_RD(rds), .I_BYTE(byt), .I_ID_SEL(ids), .O_RDATA(rdat), .I_IO_I(pin),
        .O_IO_O(oo), .O_IO_OE(oe), .O_EVENT(evt), .O_READY(rdy));
    dio_field u_field (.i_oe(oe), .i_sw(sw), .o_pin(pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic b);
        @(posedge mclk);
        addr <= a;
        wdat <= d;
        byt <= b;
        wrs <= 1'b1;
        @(posedge mclk);
        wrs <= 1'b0;
        byt <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic s, input logic b,
                        input logic [DW-1:0] e);
        @(posedge mclk);
        addr <= a;
        ids <= s;
        byt <= b;
        rds <= 1'b1;
        @(posedge mclk);
        rds <= 1'b0;
        ids <= 1'b0;
        byt <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, rdat);
    endtask
    task automatic wait_evt(input int lo, input int hi);
        int k;
        k = 0;
        while (evt !== 1'b1 && k < hi) begin
            @(posedge mclk);
            #1;
            k++;
        end
        compares++;
        if (k < lo || k >= hi) begin
            error_cnt++;
            $display("MISMATCH event delay expected %0d..%0d seen %0d", lo, hi, k);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        idle(2);
        rst_n <= 1'b1;
        wr(ADDR_DATA, 16'hffff, 1'b0);
        chk("outputs in blackout", 16'h0000, oe[15:0]);
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin
            idle(1);
            n++;
        end
        chk("ready", 16'h0001, {15'h0, rdy});
        for (int k = 0; k < 32; k++) begin
            rchk(6'(2 * k + 1), 1'b1, 1'b0, k < 12 ? {8'h00, idt[k]} : 16'h0000);
        end
        rchk(6'h02, 1'b1, 1'b0, 16'h0000);
        $display("test identification done");
        wr(ADDR_DATA, 16'ha5c3, 1'b0);
        chk("outputs word", 16'ha5c3, oe[15:0]);
        wr(ADDR_DATA, 16'h1234, 1'b1);
        chk("outputs byte", 16'ha534, oe[15:0]);
        chk("pins", 16'h5acb, pin[15:0]);
        idle(300);
        rchk(ADDR_DATA, 1'b0, 1'b0, 16'h5acb);
        rchk(ADDR_DATA, 1'b0, 1'b1, 16'h00cb);
        wr(6'h1e, 16'hffff, 1'b0);
        rchk(6'h1e, 1'b0, 1'b0, 16'h0000);
        wr(ADDR_DATA, 16'h0000, 1'b0);
        idle(300);
        $display("test outputs done");
        wr(ADDR_EN + WORD_STEP, 16'h0010, 1'b0);
        wr(ADDR_TYPE + WORD_STEP, 16'h0000, 1'b0);
        for (int c = 0; c < 3; c++) begin
            wr(ADDR_CTRL, 16'(c), 1'b0);
            sw[20] <= 1'b1;
            n = int'(cnt[c]) * CLK_MHZ / DEB_MHZ;
            wait_evt(n - 13, n + 25);
            rchk(ADDR_PEND + WORD_STEP, 1'b0, 1'b0, 16'h0010);
            wr(ADDR_PEND + WORD_STEP, 16'h0010, 1'b0);
            rchk(ADDR_PEND + WORD_STEP, 1'b0, 1'b0, 16'h0000);
            wr(ADDR_CTRL, 16'h0000, 1'b0);
            sw[20] <= 1'b0;
            idle(300);
            chk("no rising event", 16'h0000, {15'h0, evt});
        end
        $display("test durations done");
        sw[20] <= 1'b1;
        idle(100);
        sw[20] <= 1'b0;
        idle(400);
        chk("glitch event", 16'h0000, {15'h0, evt});
        rchk(ADDR_PEND + WORD_STEP, 1'b0, 1'b0, 16'h0000);
        $display("test glitch done");
        wr(ADDR_TYPE + WORD_STEP, 16'h0010, 1'b0);
        sw[20] <= 1'b1;
        idle(300);
        chk("no falling event", 16'h0000, {15'h0, evt});
        sw[20] <= 1'b0;
        wait_evt(190, 230);
        wr(ADDR_PEND + WORD_STEP, 16'h0010, 1'b0);
        $display("test rising done");
        wr(ADDR_EN, 16'h00c0, 1'b0);
        wr(ADDR_COS0, 16'h0008, 1'b0);
        for (int e = 0; e < 2; e++) begin
            sw[7] <= ~sw[7];
            wait_evt(190, 230);
            rchk(ADDR_PEND, 1'b0, 1'b0, 16'h0080);
            wr(ADDR_PEND, 16'h00c0, 1'b0);
            idle(1);
        end
        $display("test change of state done");
        wr(ADDR_CTRL, 16'h0007, 1'b0);
        rchk(ADDR_CTRL, 1'b0, 1'b0, 16'h0007);
        sw[40] <= 1'b1;
        idle(400);
        rchk(ADDR_DATA + 6'h04, 1'b0, 1'b0, 16'h7fff);
        repeat (80) begin
            idle(10);
            sw[47] <= ~sw[47];
        end
        idle(20);
        rchk(ADDR_DATA + 6'h04, 1'b0, 1'b0, 16'h7fff);
        wr(ADDR_CTRL, 16'h0004, 1'b0);
        repeat (4) begin
            idle(10);
            sw[47] <= ~sw[47];
        end
        idle(20);
        rchk(ADDR_DATA + 6'h04, 1'b0, 1'b0, 16'h7eff);
        $display("test external clock done");
        wrap_up();
    end
endmodule
